// ===== core/iwl_params.svh
// Purpose: constants of the interprocessor word link
// Assumes: included by bare name from the link design files
// Notes:   device codes sit in the low six address bits
`ifndef IWL_PARAMS_SVH
`define IWL_PARAMS_SVH

// ********************************************************
// bus address layout
// ********************************************************
`define IWL_ADDR_W       9
`define IWL_CODE_MSB     5
`define IWL_FN_MSB       7
`define IWL_FN_LSB       6
`define IWL_NIO_BIT      8

// ********************************************************
// device codes and local register codes
// ********************************************************
`define IWL_CODE_RX      6'h20
`define IWL_CODE_TX      6'h21
`define IWL_CODE_HD      6'h1E
`define IWL_CODE_FLAGS   6'h3C
`define IWL_CODE_EVSTAT  6'h3D
`define IWL_CODE_EVEN    6'h3E
`define IWL_CODE_PMASK   6'h3F

// ********************************************************
// field positions and reset values
// ********************************************************
`define IWL_PMASK_DUPLEX 8
`define IWL_PMASK_HALF   6
`define IWL_EV_RX        0
`define IWL_EV_TX        1
`define IWL_EV_HD        2
`define IWL_EV_W         3
`define IWL_BUF_RX       1'h0
`define IWL_BUF_HD       1'h1
`define IWL_PMASK_RST    16'h0000
`define IWL_EVEN_RST     3'h0
`define IWL_WORD_RST     16'h0000

`endif

// ===== core/iwl_pkg.sv
// Purpose: types of the interprocessor word link
// Assumes: nothing imported; users write iwl_pkg::name
// Notes:   one packed struct carries all state of the top module outside its word store
package iwl_pkg;

   // flag function carried with every port command
   typedef enum logic [1:0] {
      FN_NONE  = 2'h0,
      FN_START = 2'h1,
      FN_CLEAR = 2'h2,
      FN_PULSE = 2'h3
   } iwl_func_t;

   // state of the link board apart from the word buffers and read register
   typedef struct packed {
      logic        rx_busy;
      logic        rx_done;
      logic        tx_busy;
      logic        tx_done;
      logic        hd_busy;
      logic        hd_done;
      logic [2:0]  ev_stat;
      logic [2:0]  ev_en;
      logic [15:0] pmask;
      logic        lnk_release;
      logic        lnk_tx_start;
      logic        lnk_word_valid;
      logic        lnk_word_hd;
      logic [15:0] lnk_word;
      logic        lnk_hd_start;
      logic        lnk_hd_clear;
      logic        lnk_hd_pulse;
      logic        rx_req;
      logic        tx_req;
      logic        hd_req;
      logic        irq;
      logic [1:0]  tie_sync;
   } iwl_state_t;

endpackage

// ===== core/iwl_word_store.sv
// Purpose: word buffers of the link with a registered read port
// Assumes: one clock, synchronous active high reset
// Notes:   port b wins when both ports write the same word;
//          the read register also carries non-buffer read data
module iwl_word_store #(
   parameter int DEPTH = 2,
   parameter int WIDTH = 16,
   parameter int AW    = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // write port a
   input  wire logic             a_we,
   input  wire logic [AW-1:0]    a_addr,
   input  wire logic [WIDTH-1:0] a_data,
   // write port b
   input  wire logic             b_we,
   input  wire logic [AW-1:0]    b_addr,
   input  wire logic [WIDTH-1:0] b_data,
   // read port
   input  wire logic [AW-1:0]    rd_addr,
   input  wire logic             bypass_sel,
   input  wire logic [WIDTH-1:0] bypass_data,
   output logic      [WIDTH-1:0] q
);

   logic [DEPTH-1:0][WIDTH-1:0] words;

   // one register per word, whole word replaced on a write
   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_ff @(posedge clk) begin
         if (rst) begin
            words[i] <= '0;
         end else if (b_we && b_addr == AW'(i)) begin
            words[i] <= b_data;
         end else if (a_we && a_addr == AW'(i)) begin
            words[i] <= a_data;
         end
      end
   end

   // registered read, buffer contents untouched by it
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else if (bypass_sel) begin
         q <= bypass_data;
      end else begin
         q <= words[rd_addr];
      end
   end

endmodule

// ===== core/iwl_link.sv
// Purpose: flag and buffer logic of one board of a two-processor
//          word link, full-duplex pair plus shared half-duplex port
// Assumes: the peer board runs on the same clock; address bits
//          hold device code, flag function and a no-transfer bit
// Notes:   flag commands to the peer travel as one-cycle pulses
//
// Behaviour
// - sent word latched in peer receive buffer
// - sender done waits for receiver read
// - receive start sets busy, may release peer
// - receive clear zeroes flags, releases peer sender
// - pulse function on duplex ports does nothing
// - transmit start marks waiting peer receiver done
// - transmit clear zeroes local transmit flags only
// - receive done rises once peer transmits
// - data read returns buffer, flags after
// - data write replaces whole peer receive word
// - device codes 40, 41 octal, mask bit 8
// - one shared buffer for half-duplex port
// - half-duplex start grants busy to exactly one
// - half-duplex clear and pulse touch both boards
`include "iwl_params.svh"

module iwl_link (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // register port of the local processor
   input  wire logic [`IWL_ADDR_W-1:0] bus_addr,
   input  wire logic [15:0]            bus_wdata,
   input  wire logic                   bus_wr,
   input  wire logic                   bus_rd,
   output logic      [15:0]            bus_rdata,
   // flags and commands arriving from the peer board
   input  wire logic                   peer_tx_busy,
   input  wire logic                   peer_hd_busy,
   input  wire logic                   peer_release,
   input  wire logic                   peer_tx_start,
   input  wire logic                   peer_word_valid,
   input  wire logic                   peer_word_hd,
   input  wire logic [15:0]            peer_word,
   input  wire logic                   peer_hd_start,
   input  wire logic                   peer_hd_clear,
   input  wire logic                   peer_hd_pulse,
   // cable strap deciding a simultaneous half-duplex start
   input  wire logic                   hd_tie_win,
   // flags and commands sent to the peer board
   output logic                        lnk_tx_busy,
   output logic                        lnk_hd_busy,
   output logic                        lnk_release,
   output logic                        lnk_tx_start,
   output logic                        lnk_word_valid,
   output logic                        lnk_word_hd,
   output logic      [15:0]            lnk_word,
   output logic                        lnk_hd_start,
   output logic                        lnk_hd_clear,
   output logic                        lnk_hd_pulse,
   // interrupt requests to the local processor
   output logic                        rx_req,
   output logic                        tx_req,
   output logic                        hd_req,
   output logic                        irq
);

   // ********************************************************
   // decode
   // ********************************************************

   iwl_pkg::iwl_state_t s;
   iwl_pkg::iwl_state_t next_s;

   // true when the address carries the given device code
   function automatic logic code_is(
      input logic [`IWL_ADDR_W-1:0] addr,
      input logic [5:0]             code
   );
      code_is = (addr[`IWL_CODE_MSB:0] == code);
   endfunction

   iwl_pkg::iwl_func_t fn;
   logic               nio;
   logic               any_cmd;
   logic               rx_cmd;
   logic               tx_cmd;
   logic               hd_cmd;
   logic               tx_data_wr;
   logic               hd_data_wr;
   logic               rx_data_rd;
   logic               hd_data_rd;
   logic               hd_flag_clr;
   logic               mem_sel;
   logic [15:0]        byp_data;
   logic [2:0]         ev_rise;
   logic               tie_win;

   // command classes from strobes and address fields
   assign fn = iwl_pkg::iwl_func_t'(bus_addr[`IWL_FN_MSB:`IWL_FN_LSB]);
   assign nio = bus_addr[`IWL_NIO_BIT];
   assign any_cmd = bus_wr | (bus_rd & ~nio);
   assign rx_cmd = any_cmd & code_is(bus_addr, `IWL_CODE_RX);
   assign tx_cmd = any_cmd & code_is(bus_addr, `IWL_CODE_TX);
   assign hd_cmd = any_cmd & code_is(bus_addr, `IWL_CODE_HD);
   assign tx_data_wr = bus_wr & ~nio & code_is(bus_addr, `IWL_CODE_TX);
   assign hd_data_wr = bus_wr & ~nio & code_is(bus_addr, `IWL_CODE_HD);
   assign rx_data_rd = bus_rd & ~nio & code_is(bus_addr, `IWL_CODE_RX);
   assign hd_data_rd = bus_rd & ~nio & code_is(bus_addr, `IWL_CODE_HD);
   assign hd_flag_clr = bus_rd & nio & code_is(bus_addr, `IWL_CODE_HD);
   assign mem_sel = rx_data_rd | hd_data_rd;
   assign tie_win = s.tie_sync[1];

   // ********************************************************
   // register read data for non-buffer reads
   // ********************************************************

   // flag status and local registers, zero for anything else
   always_comb begin
      byp_data = 16'h0000;
      if (bus_rd && code_is(bus_addr, `IWL_CODE_FLAGS)) begin
         byp_data = {10'h000, s.hd_busy, s.hd_done, s.tx_busy,
                     s.tx_done, s.rx_busy, s.rx_done};
      end else if (bus_rd && code_is(bus_addr, `IWL_CODE_EVSTAT)) begin
         byp_data = {13'h0000, s.ev_stat};
      end else if (bus_rd && code_is(bus_addr, `IWL_CODE_EVEN)) begin
         byp_data = {13'h0000, s.ev_en};
      end else if (bus_rd && code_is(bus_addr, `IWL_CODE_PMASK)) begin
         byp_data = s.pmask;
      end
   end

   // ********************************************************
   // word buffers
   // ********************************************************

   // receive word and the one shared half-duplex word
   iwl_word_store #(
      .DEPTH (2),
      .WIDTH (16),
      .AW    (1)
   ) u_store (
      .clk         (clk),
      .rst         (rst),
      .a_we        (hd_data_wr),
      .a_addr      (`IWL_BUF_HD),
      .a_data      (bus_wdata),
      .b_we        (peer_word_valid),
      .b_addr      (peer_word_hd),
      .b_data      (peer_word),
      .rd_addr     (hd_data_rd ? `IWL_BUF_HD : `IWL_BUF_RX),
      .bypass_sel  (~mem_sel),
      .bypass_data (byp_data),
      .q           (bus_rdata)
   );

   // ********************************************************
   // next state
   // ********************************************************

   // peer effects first, then local commands on prior flags
   always_comb begin
      next_s = s;
      next_s.lnk_release = 1'b0;
      next_s.lnk_tx_start = 1'b0;
      next_s.lnk_word_valid = 1'b0;
      next_s.lnk_hd_start = 1'b0;
      next_s.lnk_hd_clear = 1'b0;
      next_s.lnk_hd_pulse = 1'b0;
      next_s.tie_sync = {s.tie_sync[0], hd_tie_win};

      // peer commands
      if (peer_release) begin
         next_s.tx_done = s.tx_busy;
         next_s.tx_busy = 1'b0;
      end
      if (peer_tx_start && s.rx_busy) begin
         next_s.rx_done = 1'b1;
      end
      if (peer_hd_clear) begin
         next_s.hd_busy = 1'b0;
      end
      if (peer_hd_pulse) begin
         next_s.hd_done = 1'b1;
      end

      // half-duplex grant waits until both start pulses have crossed
      if (s.lnk_hd_start && !peer_hd_busy
          && !(peer_hd_start && !tie_win)) begin
         next_s.hd_busy = 1'b1;
      end

      // receive port flag function
      if (rx_cmd) begin
         case (fn)
            iwl_pkg::FN_START: begin
               next_s.rx_busy = 1'b1;
               next_s.rx_done = (peer_tx_busy | peer_tx_start)
                                & ~s.rx_busy;
               next_s.lnk_release = s.rx_busy;
            end
            iwl_pkg::FN_CLEAR: begin
               next_s.rx_busy = 1'b0;
               next_s.rx_done = 1'b0;
               next_s.lnk_release = 1'b1;
            end
            iwl_pkg::FN_PULSE: begin
               next_s.rx_busy = s.rx_busy;
            end
            default: begin
               next_s.rx_busy = next_s.rx_busy;
            end
         endcase
      end

      // transmit port data and flag function
      if (tx_data_wr) begin
         next_s.lnk_word = bus_wdata;
         next_s.lnk_word_valid = 1'b1;
         next_s.lnk_word_hd = `IWL_BUF_RX;
      end
      if (tx_cmd) begin
         case (fn)
            iwl_pkg::FN_START: begin
               next_s.tx_busy = 1'b1;
               next_s.tx_done = 1'b0;
               next_s.lnk_tx_start = 1'b1;
            end
            iwl_pkg::FN_CLEAR: begin
               next_s.tx_busy = 1'b0;
               next_s.tx_done = 1'b0;
            end
            iwl_pkg::FN_PULSE: begin
               next_s.tx_busy = next_s.tx_busy;
            end
            default: begin
               next_s.tx_busy = next_s.tx_busy;
            end
         endcase
      end

      // half-duplex port data, flag function and flag clear
      if (hd_data_wr) begin
         next_s.lnk_word = bus_wdata;
         next_s.lnk_word_valid = 1'b1;
         next_s.lnk_word_hd = `IWL_BUF_HD;
      end
      if (hd_cmd) begin
         case (fn)
            iwl_pkg::FN_START: begin
               next_s.lnk_hd_start = 1'b1;
            end
            iwl_pkg::FN_CLEAR: begin
               next_s.hd_done = 1'b0;
               next_s.lnk_hd_clear = 1'b1;
            end
            iwl_pkg::FN_PULSE: begin
               next_s.hd_done = 1'b0;
               next_s.lnk_hd_pulse = 1'b1;
            end
            default: begin
               next_s.hd_done = next_s.hd_done;
            end
         endcase
      end
      if (hd_flag_clr) begin
         next_s.hd_busy = 1'b0;
         next_s.hd_done = 1'b0;
      end

      // local registers
      if (bus_wr && code_is(bus_addr, `IWL_CODE_EVSTAT)) begin
         next_s.ev_stat = s.ev_stat & ~bus_wdata[`IWL_EV_W-1:0];
      end
      if (bus_wr && code_is(bus_addr, `IWL_CODE_EVEN)) begin
         next_s.ev_en = bus_wdata[`IWL_EV_W-1:0];
      end
      if (bus_wr && code_is(bus_addr, `IWL_CODE_PMASK)) begin
         next_s.pmask = bus_wdata;
      end

      // done rising edges set sticky bits, set beats clear
      ev_rise = 3'h0;
      ev_rise[`IWL_EV_RX] = next_s.rx_done & ~s.rx_done;
      ev_rise[`IWL_EV_TX] = next_s.tx_done & ~s.tx_done;
      ev_rise[`IWL_EV_HD] = next_s.hd_done & ~s.hd_done;
      next_s.ev_stat = next_s.ev_stat | ev_rise;

      // requests follow done and the priority mask
      next_s.rx_req = next_s.rx_done
                      & ~next_s.pmask[`IWL_PMASK_DUPLEX];
      next_s.tx_req = next_s.tx_done
                      & ~next_s.pmask[`IWL_PMASK_DUPLEX];
      next_s.hd_req = next_s.hd_done & ~next_s.pmask[`IWL_PMASK_HALF];
      next_s.irq = |(next_s.ev_stat & next_s.ev_en);
   end

   // ********************************************************
   // state register
   // ********************************************************

   // single update of all flags keeps peer and local atomic
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.pmask <= `IWL_PMASK_RST;
         s.ev_en <= `IWL_EVEN_RST;
         s.lnk_word <= `IWL_WORD_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign lnk_tx_busy = s.tx_busy;
   assign lnk_hd_busy = s.hd_busy;
   assign lnk_release = s.lnk_release;
   assign lnk_tx_start = s.lnk_tx_start;
   assign lnk_word_valid = s.lnk_word_valid;
   assign lnk_word_hd = s.lnk_word_hd;
   assign lnk_word = s.lnk_word;
   assign lnk_hd_start = s.lnk_hd_start;
   assign lnk_hd_clear = s.lnk_hd_clear;
   assign lnk_hd_pulse = s.lnk_hd_pulse;
   assign rx_req = s.rx_req;
   assign tx_req = s.tx_req;
   assign hd_req = s.hd_req;
   assign irq = s.irq;

   // ********************************************************
   // checks
   // ********************************************************

   chk_rx_clear_release: assert property (
      @(posedge clk) disable iff (rst)
      rx_cmd && fn == iwl_pkg::FN_CLEAR
      |=> lnk_release && !s.rx_busy && !s.rx_done)
      else $error("receive clear did not release the peer");

   chk_rx_start_rearm: assert property (
      @(posedge clk) disable iff (rst)
      rx_cmd && fn == iwl_pkg::FN_START && s.rx_busy
      |=> lnk_release && s.rx_busy)
      else $error("receive restart did not release the peer");

   chk_rx_done_now: assert property (
      @(posedge clk) disable iff (rst)
      rx_cmd && fn == iwl_pkg::FN_START && !s.rx_busy && peer_tx_busy
      |=> s.rx_done ##1 s.rx_done || $past(bus_wr || bus_rd))
      else $error("receive done did not rise on start");

   chk_pulse_no_effect: assert property (
      @(posedge clk) disable iff (rst)
      rx_cmd && fn == iwl_pkg::FN_PULSE && !peer_tx_start
      && !peer_release
      |=> $stable({s.rx_busy, s.rx_done, s.tx_busy, s.tx_done}))
      else $error("pulse function changed a duplex flag");

   chk_tx_clear_local: assert property (
      @(posedge clk) disable iff (rst)
      tx_cmd && fn == iwl_pkg::FN_CLEAR
      |=> !s.tx_busy && !s.tx_done && !lnk_release && !lnk_tx_start)
      else $error("transmit clear misbehaved");

   chk_tx_word_send: assert property (
      @(posedge clk) disable iff (rst)
      tx_data_wr
      |=> lnk_word_valid && !lnk_word_hd && lnk_word == $past(bus_wdata))
      else $error("transmit word not sent whole");

   chk_peer_release: assert property (
      @(posedge clk) disable iff (rst)
      peer_release && !tx_cmd
      |=> !s.tx_busy && s.tx_done == $past(s.tx_busy))
      else $error("release did not complete the transmission");

   chk_rx_word_read: assert property (
      @(posedge clk) disable iff (rst)
      peer_word_valid && !peer_word_hd
      ##1 (rx_data_rd && !peer_word_valid)
      |=> bus_rdata == $past(peer_word, 2))
      else $error("received word not returned by read");

   chk_hd_grant: assert property (
      @(posedge clk) disable iff (rst)
      hd_cmd && fn == iwl_pkg::FN_START && peer_hd_busy && !s.hd_busy
      && !hd_flag_clr
      |=> lnk_hd_start ##1 (!s.hd_busy || !$past(peer_hd_busy)))
      else $error("half-duplex busy granted while peer busy");

   chk_port_request: assert property (
      @(posedge clk) disable iff (rst)
      rx_req == (s.rx_done && !s.pmask[`IWL_PMASK_DUPLEX])
      && hd_req == (s.hd_done && !s.pmask[`IWL_PMASK_HALF]))
      else $error("port request does not follow done and mask");

endmodule

// ===== tb/iwl_peer_model.sv
// Purpose: behavioural model of the link board in the other processor
// Assumes: same clock as the board under test; commands come from the bench
// Notes:   mflags uses the local flags layout {hb,hd,tb,td,rb,rd}
// ************************************************************
// peer board model
// ************************************************************
module iwl_peer_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // signals from the board under test
   input  wire logic        lnk_tx_busy,
   input  wire logic        lnk_hd_busy,
   input  wire logic        lnk_release,
   input  wire logic        lnk_tx_start,
   input  wire logic        lnk_word_valid,
   input  wire logic        lnk_word_hd,
   input  wire logic [15:0] lnk_word,
   input  wire logic        lnk_hd_clear,
   input  wire logic        lnk_hd_pulse,
   // bench commands: 1 send, 2 rx start, 3 read clear, 4 hd start,
   // 5 hd clear, 6 hd word with pulse
   input  wire logic [2:0]  cmd,
   input  wire logic [15:0] cmd_word,
   // signals to the board under test
   output logic             peer_release,
   output logic             peer_tx_start,
   output logic             peer_word_valid,
   output logic             peer_word_hd,
   output logic [15:0]      peer_word,
   output logic             peer_hd_start,
   output logic             peer_hd_clear,
   output logic             peer_hd_pulse,
   // model state seen by the bench
   output logic [5:0]       mflags,
   output logic [15:0]      m_word,
   output logic [15:0]      m_hd_word
);
   // pulses default low, an idle word line keeps toggling
   always_ff @(posedge clk) begin
      peer_release    <= 1'b0;
      peer_tx_start   <= 1'b0;
      peer_word_valid <= 1'b0;
      peer_hd_start   <= 1'b0;
      peer_word_hd    <= 1'b0;
      peer_hd_clear   <= 1'b0;
      peer_hd_pulse   <= 1'b0;
      peer_word       <= ~peer_word;
      if (rst) begin
         peer_word <= 16'h0000;
         mflags    <= 6'h00;
         m_word    <= 16'h0000;
         m_hd_word <= 16'h0000;
      end else begin
         if (lnk_release) begin
            mflags[3] <= 1'b0;
            mflags[2] <= mflags[3];
         end
         if (lnk_tx_start && mflags[1]) mflags[0] <= 1'b1;
         // words from the board under test
         if (lnk_word_valid && !lnk_word_hd) m_word <= lnk_word;
         if (lnk_word_valid && lnk_word_hd) m_hd_word <= lnk_word;
         if (lnk_hd_clear) mflags[5] <= 1'b0;
         if (lnk_hd_pulse) mflags[4] <= 1'b1;
         case (cmd)
            3'h1: begin // word sent with start
               mflags[3:2]     <= 2'h2;
               peer_tx_start   <= 1'b1;
               peer_word_valid <= 1'b1;
               peer_word       <= cmd_word;
            end
            3'h2: begin // receive start
               mflags[1]    <= 1'b1;
               mflags[0]    <= lnk_tx_busy & ~mflags[1];
               peer_release <= mflags[1];
            end
            3'h3: begin // read with clear
               mflags[1:0]  <= 2'h0;
               peer_release <= 1'b1;
            end
            3'h4: begin // half-duplex start
               if (!lnk_hd_busy) mflags[5] <= 1'b1;
               peer_hd_start <= 1'b1;
            end
            3'h5: begin // half-duplex clear
               mflags[4]     <= 1'b0;
               peer_hd_clear <= 1'b1;
            end
            3'h6: begin // half-duplex word with pulse
               mflags[4]       <= 1'b0;
               m_hd_word       <= cmd_word;
               peer_hd_pulse   <= 1'b1;
               peer_word_valid <= 1'b1;
               peer_word_hd    <= 1'b1;
               peer_word       <= cmd_word;
            end
            default: ;
         endcase
      end
   end
endmodule

// ===== tb/iwl_link_tb.sv
// Purpose: self-checking bench of the interprocessor word link
// Assumes: peer model joined by crossing link signals
// Notes:   flag commands use no-transfer accesses, bit 8 of the address set, or ride on data transfers
`include "iwl_params.svh"
module iwl_link_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic        clk, rst, bus_wr, bus_rd, hd_tie_win;
   logic [8:0]  bus_addr;
   logic [15:0] bus_wdata, bus_rdata, peer_word, lnk_word, cmd_word;
   logic        peer_release, peer_tx_start, peer_word_valid, peer_hd_start;
   logic        peer_word_hd, peer_hd_clear, peer_hd_pulse;
   logic        lnk_tx_busy, lnk_hd_busy, lnk_release, lnk_tx_start;
   logic        lnk_word_valid, lnk_word_hd, lnk_hd_start, lnk_hd_clear;
   logic        lnk_hd_pulse, rx_req, tx_req, hd_req, irq;
   logic [2:0]  cmd;
   logic [5:0]  mflags;
   logic [15:0] m_word, m_hd_word;
   int          bad_count, total_checks;
   iwl_link dut (.clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
      .bus_rdata, .peer_tx_busy(mflags[3]), .peer_hd_busy(mflags[5]),
      .peer_release, .peer_tx_start, .peer_word_valid,
      .peer_word_hd, .peer_word, .peer_hd_start,
      .peer_hd_clear, .peer_hd_pulse, .hd_tie_win,
      .lnk_tx_busy, .lnk_hd_busy, .lnk_release, .lnk_tx_start,
      .lnk_word_valid, .lnk_word_hd, .lnk_word, .lnk_hd_start,
      .lnk_hd_clear, .lnk_hd_pulse, .rx_req, .tx_req, .hd_req, .irq);
   iwl_peer_model peer (.clk, .rst, .lnk_tx_busy, .lnk_hd_busy,
      .lnk_release, .lnk_tx_start, .lnk_word_valid, .lnk_word_hd,
      .lnk_word, .lnk_hd_clear, .lnk_hd_pulse, .cmd, .cmd_word,
      .peer_release, .peer_tx_start, .peer_word_valid, .peer_word,
      .peer_hd_start, .peer_word_hd, .peer_hd_clear, .peer_hd_pulse,
      .mflags, .m_word, .m_hd_word);
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [15:0] e);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 check(bus_rdata, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // flags register after the round trip across both boards settles
   task automatic fl(input logic [15:0] e);
      idle(3);
      rd(9'h03C, e);
   endtask
   task automatic peer_cmd(input logic [2:0] c, input logic [15:0] w);
      @(posedge clk);
      cmd      <= c;
      cmd_word <= w;
      @(posedge clk);
      cmd <= 3'h0;
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ************************************************************
   // clock, watchdog and test sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // cuts a hang short
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      {rst, bus_wr, bus_rd, hd_tie_win} = 4'h9;
      {bus_addr, bus_wdata, cmd, cmd_word} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wr(9'h160, 16'h0000);
      fl(16'h0002);
      peer_cmd(3'h1, 16'hA5A5);
      fl(16'h0003);
      check({15'h0, rx_req}, 16'h0001);
      check({10'h0, mflags}, 16'h0008);
      rd(9'h03D, 16'h0001);
      wr(9'h03E, 16'h0001);
      idle(2);
      check({15'h0, irq}, 16'h0001);
      wr(9'h03D, 16'h0001);
      idle(2);
      check({15'h0, irq}, 16'h0000);
      rd(9'h0A0, 16'hA5A5);
      fl(16'h0000);
      check({10'h0, mflags}, 16'h0004);
      rd(9'h020, 16'hA5A5);
      wr(9'h160, 16'h0000);
      rd(9'h1E0, 16'h0000);
      wr(9'h1E0, 16'h0000);
      wr(9'h1E1, 16'h0000);
      fl(16'h0002);
      rd(9'h020, 16'hA5A5);
      peer_cmd(3'h1, 16'hBEEF);
      fl(16'h0003);
      rd(9'h060, 16'hBEEF);
      fl(16'h0002);
      check({10'h0, mflags}, 16'h0004);
      wr(9'h1A0, 16'h0000);
      peer_cmd(3'h1, 16'h1357);
      fl(16'h0000);
      wr(9'h160, 16'h0000);
      fl(16'h0003);
      rd(9'h0A0, 16'h1357);
      peer_cmd(3'h2, 16'h0000);
      wr(9'h061, 16'h1234);
      fl(16'h0008);
      check({10'h0, mflags}, 16'h0007);
      check(m_word, 16'h1234);
      peer_cmd(3'h3, 16'h0000);
      fl(16'h0004);
      check({15'h0, tx_req}, 16'h0001);
      wr(9'h03F, 16'h0100);
      idle(2);
      check({15'h0, tx_req}, 16'h0000);
      wr(9'h061, 16'h0F0F);
      wr(9'h1A1, 16'h0000);
      fl(16'h0000);
      check({10'h0, mflags}, 16'h0004);
      check(m_word, 16'h0F0F);
      peer_cmd(3'h4, 16'h0000);
      wr(9'h15E, 16'h0000);
      fl(16'h0000);
      check({10'h0, mflags}, 16'h0024);
      wr(9'h19E, 16'h0000);
      idle(3);
      check({10'h0, mflags}, 16'h0004);
      wr(9'h15E, 16'h0000);
      fl(16'h0020);
      wr(9'h0DE, 16'h5555);
      fl(16'h0020);
      check({10'h0, mflags}, 16'h0014);
      check(m_hd_word, 16'h5555);
      peer_cmd(3'h6, 16'h6A6A);
      fl(16'h0030);
      check({15'h0, hd_req}, 16'h0001);
      rd(9'h01E, 16'h6A6A);
      peer_cmd(3'h5, 16'h0000);
      fl(16'h0010);
      rd(9'h11E, 16'h0000);
      fl(16'h0000);
      check({15'h0, hd_req}, 16'h0000);
      report_and_stop();
   end
endmodule
